// ### src/cbt_map.vh
// Constants for the CAN bit-timing and receive mailbox block.
// Assumes a 32-bit byte-addressed register port; offsets are byte addresses.
`ifndef CBT_MAP_VH
`define CBT_MAP_VH
// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define CBT_ADDR_W            32
`define CBT_MASTER_CONTROL    32'hffffd800
`define CBT_TIMING_SEGMENTS   32'hffffd804
`define CBT_TIMING_PRESCALER  32'hffffd806
`define CBT_INTERRUPT_MASK    32'hffffd80a
`define CBT_IRQ_FLAGS         32'hffffd80c
`define CBT_GLOBAL_STATUS     32'hffffd80e
`define CBT_RX_PENDING        32'hffffd842
`define CBT_BOX0_MASK         32'hffffd904
`define CBT_BOX0_PAYLOAD      32'hffffd908
`define CBT_BOX0_CONTROL0     32'hffffd900
`define CBT_BOX0_CONTROL1     32'hffffd910
`define CBT_BOX1_CONTROL0     32'hffffd920
`define CBT_BOX1_CONTROL1     32'hffffd930
`define CBT_STANDBY_CONTROL   32'hffffe806
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CBT_MCR_CFG_BIT       0
`define CBT_MCR_NATIVE_BIT    15
`define CBT_SEG1_LSB          12
`define CBT_SEG2_LSB          8
`define CBT_SJW_LSB           4
`define CBT_BSP_BIT           0
`define CBT_ROLE_LSB          8
`define CBT_DLC_LSB           0
`define CBT_GSR_RESET_BIT     3
`define CBT_IRR_RESET_BIT     0
`define CBT_STOP_BIT          0
`define CBT_ID_LSB            18
`define CBT_IDE_BIT           31
`define CBT_RTR_BIT           30
// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define CBT_ROLE_RX           3'h2
`define CBT_ROLE_TX           3'h0
`define CBT_MCR_RESET         16'h0001
`define CBT_MASK_RESET        16'hffff
`define CBT_STANDBY_RESET     8'h01
`define CBT_SYNC_TQ           5'h01
`endif

// ### src/cbt_can_core.v
// CAN bit-timing engine with a receive mailbox and its register port.
// Assumes the CAN receive level is already synchronous to clk_sys_i and
// that a frame decoder outside raises frame_done_i with the decoded frame.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "cbt_map.vh"

module cbt_can_core #(
   parameter NUM_BOXES = 16
) (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   input  wire [31:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   input  wire        can_rx_i,
   input  wire        frame_done_i,
   input  wire [3:0]  frame_box_i,
   input  wire        frame_ide_i,
   input  wire        frame_rtr_i,
   input  wire [28:0] frame_id_i,
   input  wire [3:0]  frame_dlc_i,
   input  wire [63:0] frame_data_i,
   output reg         sample_pulse_o,
   output reg         sample_bit_o,
   output reg         bit_end_o,
   output wire        bus_active_o,
   output wire        irq_o
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   reg  [15:0] master_r;
   reg  [15:0] segments_r;
   reg  [15:0] prescaler_r;
   reg  [15:0] imask_r;
   reg  [15:0] irq_flags_r;
   reg  [15:0] rx_pend_r;
   reg  [7:0]  standby_r;
   reg         in_cfg_r;
   // Only box 0 stores frames; box 1 keeps its transmit setup for
   // software. The other boxes of the full set are left out here.
   reg  [31:0] box0_mask_r;    // Acceptance mask of box 0 only; box 1 has none
   reg  [31:0] box0_ctl0_r;
   reg  [15:0] box0_ctl1_r;
   reg  [63:0] box0_data_r;
   reg  [31:0] box1_ctl0_r;
   reg  [15:0] box1_ctl1_r;

   wire        stopped  = standby_r[`CBT_STOP_BIT];
   wire        run      = clk_en_i & ~stopped;
   wire        cfg_req  = master_r[`CBT_MCR_CFG_BIT];
   wire        cfg_wr   = reg_wr_i & in_cfg_r;
   wire [3:0]  seg1_set = segments_r[`CBT_SEG1_LSB +: 4];
   wire [2:0]  seg2_set = segments_r[`CBT_SEG2_LSB +: 3];
   wire [1:0]  sjw_set  = segments_r[`CBT_SJW_LSB +: 2];
   wire [7:0]  brp_set  = prescaler_r[7:0];
   wire [2:0]  box0_role = box0_ctl1_r[`CBT_ROLE_LSB +: 3];

   assign bus_active_o = ~in_cfg_r & ~stopped;
   // Every source has one mask bit; all ones blocks them all
   assign irq_o = |(irq_flags_r & ~imask_r);

   // ---------------------------------------------------------------
   // Time quantum prescaler
   // ---------------------------------------------------------------
   // Quantum is 2*(brp+1) clocks, counted as a 9-bit down counter
   // The counter reloads while off the bus so the first quantum after
   // leaving configuration is a full one
   reg  [8:0] tq_cnt_r;
   wire [8:0] tq_len = {brp_set, 1'b1};
   wire       tq_tick = (tq_cnt_r == 9'h000);

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tq_cnt_r <= 9'h000;
      end else if (run) begin
         if (!bus_active_o || tq_tick) begin
            tq_cnt_r <= tq_len;
         end else begin
            tq_cnt_r <= tq_cnt_r - 9'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bit segment sequencer
   // ---------------------------------------------------------------
   localparam ST_SYNC = 3'b001;
   localparam ST_SEG1 = 3'b010;
   localparam ST_SEG2 = 3'b100;

   reg  [2:0] state_r;
   reg  [4:0] seg_cnt_r;     // Quanta left in the current segment
   reg        rx_prev_r;
   reg        hard_sync_ok_r;
   reg  [4:0] seg_cnt_nxt;
   reg  [2:0] state_nxt;
   reg        bit_end_nxt;
   reg        sample_nxt;

   wire [4:0] seg1_len = {1'b0, seg1_set} + 5'h01;
   wire [4:0] seg2_len = {2'b00, seg2_set} + 5'h01;
   wire [4:0] sjw_len  = {3'b000, sjw_set} + 5'h01;
   wire       fall_edge = rx_prev_r & ~can_rx_i;
   // Phase error measured from quanta still left in seg1 or seg2
   wire [4:0] late_err  = (seg1_len - seg_cnt_r);
   wire [4:0] early_err = seg_cnt_r;

   // Edges are seen only at quantum ticks, so phase error is known to
   // one quantum; finer timing would need a per-clock edge capture
   // Next-segment selection with resynchronisation on recessive-to-dominant edges.
   // Edges inside the sync quantum need no correction.
   always @* begin
      state_nxt   = state_r;
      seg_cnt_nxt = seg_cnt_r;
      bit_end_nxt = 1'b0;
      sample_nxt  = 1'b0;
      case (state_r)
         ST_SYNC: begin
            state_nxt   = ST_SEG1;
            seg_cnt_nxt = seg1_len;
         end
         ST_SEG1: begin
            if (fall_edge && hard_sync_ok_r) begin
               // Late edge: stretch phase one by at most jump width
               seg_cnt_nxt = seg_cnt_r + ((late_err > sjw_len) ?
                             sjw_len : late_err);
            end else if (seg_cnt_r <= 5'h01) begin
               state_nxt   = ST_SEG2;
               seg_cnt_nxt = seg2_len;
               sample_nxt  = 1'b1;
            end else begin
               seg_cnt_nxt = seg_cnt_r - 5'h01;
            end
         end
         ST_SEG2: begin
            if (fall_edge && hard_sync_ok_r &&
                early_err <= sjw_len) begin
               // Early edge: cut phase two, start next bit now
               state_nxt   = ST_SYNC;
               bit_end_nxt = 1'b1;
            end else if (seg_cnt_r <= 5'h01) begin
               state_nxt   = ST_SYNC;
               bit_end_nxt = 1'b1;
            end else if (fall_edge && hard_sync_ok_r) begin
               seg_cnt_nxt = seg_cnt_r - sjw_len;
            end else begin
               seg_cnt_nxt = seg_cnt_r - 5'h01;
            end
         end
         default: begin
            state_nxt   = ST_SYNC;
            seg_cnt_nxt = 5'h00;
         end
      endcase
   end

   // Segment registers advance once per quantum while on the bus
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r        <= ST_SYNC;
         seg_cnt_r      <= 5'h00;
         rx_prev_r      <= 1'b1;
         hard_sync_ok_r <= 1'b0;
         sample_pulse_o <= 1'b0;
         sample_bit_o   <= 1'b1;
         bit_end_o      <= 1'b0;
      end else if (run) begin
         sample_pulse_o <= 1'b0;
         bit_end_o      <= 1'b0;
         if (!bus_active_o) begin
            state_r        <= ST_SYNC;
            seg_cnt_r      <= `CBT_SYNC_TQ;
            hard_sync_ok_r <= 1'b0;
         end else if (tq_tick) begin
            rx_prev_r      <= can_rx_i;
            hard_sync_ok_r <= 1'b1;
            state_r        <= state_nxt;
            seg_cnt_r      <= seg_cnt_nxt;
            bit_end_o      <= bit_end_nxt;
            sample_pulse_o <= sample_nxt;
            if (sample_nxt) begin
               sample_bit_o <= can_rx_i;
            end
         end
      end else if (clk_en_i) begin
         // A stop must not freeze a pulse high for the whole stop
         sample_pulse_o <= 1'b0;
         bit_end_o      <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Configuration mode handshake
   // ---------------------------------------------------------------
   // Mode changes wait for a bit boundary so no frame is cut mid-bit
   wire mode_enter = cfg_req & ~in_cfg_r;
   wire mode_leave = ~cfg_req & in_cfg_r;
   wire at_bound   = ~bus_active_o | bit_end_o;
   // A request made while already in configuration is answered at once,
   // so software polling the request flag never waits for nothing
   wire cfg_reached = (at_bound & mode_enter) |
                      (reg_wr_i & (reg_addr_i == `CBT_MASTER_CONTROL) &
                       reg_wdata_i[`CBT_MCR_CFG_BIT] & in_cfg_r);

   // ---------------------------------------------------------------
   // Acceptance and receive store for box 0
   // ---------------------------------------------------------------
   // Mask bit one means don't care; zero mask needs exact match
   // Keys follow the control word layout: IDE, RTR, a spare bit, then
   // the identifier, so the format flag lines up with bit 31
   wire [31:0] frame_key = {frame_ide_i, frame_rtr_i, 1'b0,
                            frame_id_i[28:18],
                            frame_id_i[17:0] & {18{frame_ide_i}}};
   wire [31:0] box_key   = {box0_ctl0_r[`CBT_IDE_BIT],
                            box0_ctl0_r[`CBT_RTR_BIT],
                            1'b0,
                            box0_ctl0_r[`CBT_ID_LSB +: 11],
                            box0_ctl0_r[17:0]};
   wire [31:0] key_diff  = (frame_key ^ box_key) & ~box0_mask_r;
   // Standard or extended both matched; IDE takes part in the key
   wire        box0_hit  = frame_done_i & bus_active_o &
                           (frame_box_i == 4'h0) &
                           (box0_role == `CBT_ROLE_RX) &
                           ~frame_rtr_i &
                           (key_diff[31] == 1'b0) &
                           (key_diff[29:0] == 30'h0);
   wire [15:0] box0_set  = {15'h0000, box0_hit};

   // ---------------------------------------------------------------
   // Register writes and hardware-set flags
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         master_r    <= `CBT_MCR_RESET;
         segments_r  <= 16'h0000;
         prescaler_r <= 16'h0000;
         imask_r     <= `CBT_MASK_RESET;
         irq_flags_r <= 16'h0000;
         rx_pend_r   <= 16'h0000;
         standby_r   <= `CBT_STANDBY_RESET;
         in_cfg_r    <= 1'b1;
         box0_mask_r <= 32'h00000000;
         box0_ctl0_r <= 32'h00000000;
         box0_ctl1_r <= 16'h0000;
         box0_data_r <= 64'h0000000000000000;
         box1_ctl0_r <= 32'h00000000;
         box1_ctl1_r <= 16'h0000;
      end else if (clk_en_i) begin
         // The stop bit stays writable while stopped, or the block could
         // never be woken again
         if (reg_wr_i && reg_addr_i == `CBT_STANDBY_CONTROL) begin
            standby_r <= reg_wdata_i[7:0];
         end
         if (!stopped) begin
            if (reg_wr_i && reg_addr_i == `CBT_MASTER_CONTROL) begin
               master_r <= reg_wdata_i[15:0];
            end
            if (reg_wr_i && reg_addr_i == `CBT_INTERRUPT_MASK) begin
               imask_r <= reg_wdata_i[15:0];
            end
            if (cfg_wr && reg_addr_i == `CBT_TIMING_SEGMENTS) begin
               segments_r <= reg_wdata_i[15:0];
            end
            if (cfg_wr && reg_addr_i == `CBT_TIMING_PRESCALER) begin
               prescaler_r <= reg_wdata_i[15:0];
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX0_MASK) begin
               box0_mask_r <= reg_wdata_i;
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX0_CONTROL0) begin
               box0_ctl0_r <= reg_wdata_i;
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX0_CONTROL1) begin
               box0_ctl1_r <= reg_wdata_i[15:0];
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX1_CONTROL0) begin
               box1_ctl0_r <= reg_wdata_i;
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX1_CONTROL1) begin
               box1_ctl1_r <= reg_wdata_i[15:0];
            end
            if (cfg_wr && reg_addr_i == `CBT_BOX0_PAYLOAD) begin
               box0_data_r[63:48] <= reg_wdata_i[15:0];
            end
            // Mode change only at a bit boundary
            if (at_bound && (mode_enter || mode_leave)) begin
               in_cfg_r <= cfg_req;
            end
            // Write one clears; a same-cycle set wins over the clear
            irq_flags_r <= (irq_flags_r &
               ~((reg_wr_i && reg_addr_i == `CBT_IRQ_FLAGS) ?
                 reg_wdata_i[15:0] : 16'h0000)) |
               {15'h0000, cfg_reached};
            rx_pend_r <= (rx_pend_r &
               ~((reg_wr_i && reg_addr_i == `CBT_RX_PENDING) ?
                 reg_wdata_i[15:0] : 16'h0000)) | box0_set;
            if (box0_hit) begin
               box0_data_r <= frame_data_i;
               box0_ctl1_r[`CBT_DLC_LSB +: 4] <= frame_dlc_i;
               box0_ctl0_r[`CBT_ID_LSB +: 11] <= frame_id_i[28:18];
               box0_ctl0_r[17:0] <= frame_id_i[17:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Register read port, data one cycle after the strobe
   // ---------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      case (reg_addr_i)
         `CBT_MASTER_CONTROL:   rd_mux = {16'h0000, master_r};
         `CBT_TIMING_SEGMENTS:  rd_mux = {16'h0000, segments_r};
         `CBT_TIMING_PRESCALER: rd_mux = {16'h0000, prescaler_r};
         `CBT_INTERRUPT_MASK:   rd_mux = {16'h0000, imask_r};
         `CBT_IRQ_FLAGS:        rd_mux = {16'h0000, irq_flags_r};
         `CBT_GLOBAL_STATUS:    rd_mux = {28'h0000000, in_cfg_r,
                                          3'b000};
         `CBT_RX_PENDING:       rd_mux = {16'h0000, rx_pend_r};
         `CBT_BOX0_MASK:        rd_mux = box0_mask_r;
         `CBT_BOX0_PAYLOAD:     rd_mux = {16'h0000, box0_data_r[63:48]};
         `CBT_BOX0_CONTROL0:    rd_mux = box0_ctl0_r;
         `CBT_BOX0_CONTROL1:    rd_mux = {16'h0000, box0_ctl1_r};
         `CBT_BOX1_CONTROL0:    rd_mux = box1_ctl0_r;
         `CBT_BOX1_CONTROL1:    rd_mux = {16'h0000, box1_ctl1_r};
         `CBT_STANDBY_CONTROL:  rd_mux = {24'h000000, standby_r};
         default:               rd_mux = 32'h00000000;
      endcase
   end

   // Unmapped addresses read zero
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (clk_en_i) begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
      end
   end

endmodule // cbt_can_core

// ### dv/cbt_can_checker.sv
// Checker for the CAN bit-timing block, bound to its top module.
// Assumes clk_en_i stays high; shadows track register writes.
`timescale 1ns/1ps
`include "cbt_map.vh"

module cbt_can_checker (
   input wire        clk_sys_i,
   input wire        rst_n_i,
   input wire        clk_en_i,
   input wire [31:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [31:0] reg_rdata_o,
   input wire        can_rx_i,
   input wire        sample_pulse_o,
   input wire        bit_end_o,
   input wire        bus_active_o,
   input wire        irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   reg        stop_r, seen_r, edge_r, edge_old_r, rx_q_r;
   reg [15:0] mask_r, seg_r, brp_r, gap_r, sgap_r;
   wire       wr_ok = reg_wr_i && clk_en_i && !stop_r;
   wire       cfg   = !bus_active_o && !stop_r;
   wire       rx_ed = can_rx_i != rx_q_r;
   wire [15:0] tq   = {7'h0, brp_r[7:0], 1'b0} + 16'h2;
   wire [15:0] blen = tq * ({12'h0, seg_r[15:12]} + {13'h0, seg_r[10:8]}
                      + 16'h3);
   wire [15:0] s2   = tq * ({13'h0, seg_r[10:8]} + 16'h1);
   wire        calm = bit_end_o && seen_r && !edge_r && !edge_old_r;
   // ------------------------------------------------------------
   // Shadows; bits with a bus edge are skipped since resync moves them
   // ------------------------------------------------------------
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_r <= 1'b1; mask_r <= 16'hffff; seg_r <= 16'h0;
         brp_r <= 16'h0; gap_r <= 16'h0; sgap_r <= 16'h0; seen_r <= 1'b0;
         edge_r <= 1'b1; edge_old_r <= 1'b1; rx_q_r <= 1'b1;
      end else begin
         if (reg_wr_i && clk_en_i && reg_addr_i == `CBT_STANDBY_CONTROL)
            stop_r <= reg_wdata_i[`CBT_STOP_BIT];
         if (wr_ok && reg_addr_i == `CBT_INTERRUPT_MASK)
            mask_r <= reg_wdata_i[15:0];
         if (wr_ok && cfg && reg_addr_i == `CBT_TIMING_SEGMENTS)
            seg_r <= reg_wdata_i[15:0];
         if (wr_ok && cfg && reg_addr_i == `CBT_TIMING_PRESCALER)
            brp_r <= reg_wdata_i[15:0];
         rx_q_r <= can_rx_i;
         gap_r  <= bit_end_o ? 16'h1 : gap_r + 16'h1;
         sgap_r <= sample_pulse_o ? 16'h1 : sgap_r + 16'h1;
         seen_r <= bus_active_o && (seen_r || bit_end_o);
         edge_r <= bit_end_o ? rx_ed : (edge_r || rx_ed);
         if (bit_end_o) edge_old_r <= edge_r || rx_ed;
      end
   end

   chk_bit_length: assert property (calm |-> gap_r == blen)
      else $error("bit length wrong");
   chk_seg_two: assert property (calm |-> sgap_r == s2)
      else $error("second segment length wrong");
   chk_sample_once: assert property (
      sample_pulse_o |=> !sample_pulse_o)
      else $error("sample pulse longer than a cycle");
   chk_sync_apart: assert property (sample_pulse_o |-> !bit_end_o)
      else $error("sample point on bit end");
   chk_mask_quiet: assert property (mask_r == 16'hffff |-> !irq_o)
      else $error("interrupt with all masked");
   chk_stop_quiet: assert property (stop_r |-> !bus_active_o)
      else $error("active while stopped");
   chk_cfg_quiet: assert property (
      !bus_active_o && $past(!bus_active_o) |-> !sample_pulse_o)
      else $error("sampling in configuration");
   chk_leave_cfg: assert property (
      wr_ok && reg_addr_i == `CBT_MASTER_CONTROL && !reg_wdata_i[0]
      |-> ##[1:3] bus_active_o)
      else $error("configuration not left");
   chk_rdata_zero: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside read slot");
   cover property (bit_end_o && seen_r);
   cover property (irq_o);
   cover property ($fell(bus_active_o));
endmodule // cbt_can_checker

bind cbt_can_core cbt_can_checker cbt_can_checker_i (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .can_rx_i(can_rx_i), .sample_pulse_o(sample_pulse_o),
   .bit_end_o(bit_end_o), .bus_active_o(bus_active_o), .irq_o(irq_o));

// ### dv/cbt_can_node.sv
// Behavioural model of another node sending a standard data frame.
// Assumes the block's decoder view: fields valid with the done pulse.
`timescale 1ns/1ps

module cbt_can_node #(
   parameter BIT_CLKS = 80
) (
   input  wire        clk_i,
   input  wire        send_i,
   input  wire [10:0] id_i,
   input  wire [3:0]  dlc_i,
   input  wire [63:0] data_i,
   output reg         can_rx_o,
   output reg         busy_o,
   output reg         frame_done_o,
   output reg  [3:0]  frame_box_o,
   output reg         frame_ide_o,
   output reg         frame_rtr_o,
   output reg  [28:0] frame_id_o,
   output reg  [3:0]  frame_dlc_o,
   output reg  [63:0] frame_data_o
);
   integer k;
   // Fields start inverted; identifier and data idle inverted so a stale read of them never looks right
   initial begin
      can_rx_o = 1'b1; busy_o = 1'b0; frame_done_o = 1'b0;
      frame_box_o = 4'hf; frame_ide_o = 1'b1; frame_rtr_o = 1'b1;
      frame_id_o = 29'h1fffffff; frame_dlc_o = 4'hf;
      frame_data_o = {64{1'b1}};
   end
   // Start bit then identifier, most significant first
   always @(posedge clk_i) begin
      if (send_i && !busy_o) begin
         busy_o <= 1'b1;
         for (k = 0; k < 12; k = k + 1) begin
            can_rx_o <= (k == 0) ? 1'b0 : id_i[11-k];
            repeat (BIT_CLKS) @(posedge clk_i);
         end
         can_rx_o     <= 1'b1;
         frame_box_o  <= 4'h0;
         frame_ide_o  <= 1'b0;
         frame_rtr_o  <= 1'b0;
         frame_id_o   <= {id_i, 18'h0};
         frame_dlc_o  <= dlc_i;
         frame_data_o <= data_i;
         frame_done_o <= 1'b1;
         @(posedge clk_i);
         frame_done_o <= 1'b0;
         frame_id_o   <= ~{id_i, 18'h0};
         frame_data_o <= ~data_i;
         busy_o       <= 1'b0;
      end
   end
endmodule // cbt_can_node

// ### dv/testbench.sv
// Self-checking bench for the CAN bit-timing block and receive box.
// Assumes the node model matches an 80-clock bit.
`timescale 1ns/1ps
`include "cbt_map.vh"

module testbench;
   reg         clk_sys_i = 1'b0, rst_n_i = 1'b0, send = 1'b0;
   reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   reg  [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0, d;
   reg  [10:0] tx_id = 11'h0;
   wire [31:0] rdata;
   wire        rx, fdone, fide, frtr, sp, sb, be, act, irq, busy;
   wire [3:0]  fbox, fdlc;
   wire [28:0] fid;
   wire [63:0] fdata;
   integer     failures = 0, check_count = 0, n;

   cbt_can_core cbt_can_core_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .clk_en_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
      .can_rx_i(rx), .frame_done_i(fdone), .frame_box_i(fbox),
      .frame_ide_i(fide), .frame_rtr_i(frtr), .frame_id_i(fid),
      .frame_dlc_i(fdlc), .frame_data_i(fdata), .sample_pulse_o(sp),
      .sample_bit_o(sb), .bit_end_o(be), .bus_active_o(act), .irq_o(irq));
   cbt_can_node #(.BIT_CLKS(80)) cbt_can_node_i (.clk_i(clk_sys_i),
      .send_i(send), .id_i(tx_id), .dlc_i(4'h2),
      .data_i(64'hc1c2_0000_0000_0000), .can_rx_o(rx), .busy_o(busy),
      .frame_done_o(fdone), .frame_box_o(fbox), .frame_ide_o(fide),
      .frame_rtr_o(frtr), .frame_id_o(fid), .frame_dlc_o(fdlc),
      .frame_data_o(fdata));

   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   // ------------------------------------------------------------
   // Register bus and comparison tasks
   // ------------------------------------------------------------
   task wr(input [31:0] a, input [31:0] v);
      begin
         @(posedge clk_sys_i);
         reg_addr_i <= a; reg_wdata_i <= v; reg_wr_i <= 1'b1;
         @(posedge clk_sys_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   task rd(input [31:0] a, output [31:0] v);
      begin
         @(posedge clk_sys_i);
         reg_addr_i <= a; reg_rd_i <= 1'b1;
         @(posedge clk_sys_i);
         reg_rd_i <= 1'b0;
         #1 v = rdata;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      begin
         rd(`CBT_MASTER_CONTROL, d); chk(d, 32'h1);
         rd(`CBT_INTERRUPT_MASK, d); chk(d, 32'hffff);
         rd(`CBT_STANDBY_CONTROL, d); chk(d, 32'h1);
         rd(`CBT_GLOBAL_STATUS, d); chk(d & 32'h8, 32'h8);
         chk(act, 1'b0);
         wr(`CBT_MASTER_CONTROL, 32'h8001);
         rd(`CBT_MASTER_CONTROL, d); chk(d, 32'h1);
         wr(`CBT_STANDBY_CONTROL, 32'h0);
      end
   endtask
   task t_config;
      begin
         wr(`CBT_MASTER_CONTROL, 32'h1);
         d = 32'h0; n = 0;
         while (d[0] !== 1'b1 && n < 50) begin
            rd(`CBT_IRQ_FLAGS, d); n = n + 1;
         end
         chk(d[0], 1'b1);
         chk(irq, 1'b0);
         wr(`CBT_INTERRUPT_MASK, 32'hfffe);
         @(negedge clk_sys_i); chk(irq, 1'b1);
         wr(`CBT_IRQ_FLAGS, 32'h1);
         rd(`CBT_IRQ_FLAGS, d); chk(d[0], 1'b0);
         wr(`CBT_INTERRUPT_MASK, 32'hffff);
      end
   endtask
   task t_setup;
      begin
         wr(`CBT_TIMING_SEGMENTS, 32'h5200);
         wr(`CBT_TIMING_PRESCALER, 32'h3);
         wr(`CBT_BOX0_CONTROL1, 32'h0200);
         wr(`CBT_BOX0_CONTROL0, 32'h0);
         wr(`CBT_BOX0_MASK, 32'h0);
         rd(`CBT_TIMING_SEGMENTS, d); chk(d, 32'h5200);
         rd(`CBT_TIMING_PRESCALER, d); chk(d, 32'h3);
         rd(`CBT_BOX0_CONTROL1, d); chk(d, 32'h0200);
         wr(`CBT_MASTER_CONTROL, 32'h8000);
         d = 32'h8; n = 0;
         while (d[3] !== 1'b0 && n < 50) begin
            rd(`CBT_GLOBAL_STATUS, d); n = n + 1;
         end
         chk(d[3], 1'b0);
         chk(act, 1'b1);
         rd(`CBT_MASTER_CONTROL, d); chk(d, 32'h8000);
      end
   endtask
   // Quantum 8 clocks, bit 10 quanta, second segment 3 quanta
   task t_timing;
      begin
         n = 0;
         while (be !== 1'b1 && n < 200) begin @(negedge clk_sys_i); n++; end
         n = 0;
         do begin @(negedge clk_sys_i); n++; end while (be !== 1'b1 && n < 200);
         chk(n, 80);
         while (sp !== 1'b1 && n < 400) begin @(negedge clk_sys_i); n++; end
         n = 0;
         do begin @(negedge clk_sys_i); n++; end while (be !== 1'b1 && n < 200);
         chk(n, 24);
         wr(`CBT_TIMING_SEGMENTS, 32'h3100);
         rd(`CBT_TIMING_SEGMENTS, d); chk(d, 32'h5200);
      end
   endtask
   task frame(input [10:0] id, input [31:0] exp);
      begin
         @(posedge clk_sys_i); tx_id <= id; send <= 1'b1;
         @(posedge clk_sys_i); send <= 1'b0;
         repeat (2) @(posedge sp);
         @(negedge clk_sys_i); chk(sb, 1'b0);
         n = 0;
         while (busy !== 1'b0 && n < 3000) begin @(negedge clk_sys_i); n++; end
         rd(`CBT_RX_PENDING, d); chk(d, exp);
      end
   endtask
   task t_rx;
      begin
         frame(11'h005, 32'h0);
         frame(11'h000, 32'h1);
         rd(`CBT_BOX0_PAYLOAD, d); chk(d, 32'hc1c2);
         rd(`CBT_BOX0_CONTROL1, d); chk(d[3:0], 4'h2);
         rd(`CBT_BOX0_CONTROL0, d); chk(d[31:18], 14'h0);
         wr(`CBT_RX_PENDING, 32'h1);
         rd(`CBT_RX_PENDING, d); chk(d, 32'h0);
      end
   endtask

   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_reset; t_config; t_setup; t_timing; t_rx;
      results;
   end
   // Watchdog well beyond the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      failures = failures + 1;
      results;
   end
endmodule // testbench
